// ===== core/psm_defs.svh
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// -----------------------------------------------------------------------------
// Register layout and constants
// -----------------------------------------------------------------------------

// Condition and event words are 16 bits wide; only bit 9 carries meaning.
`define PSM_WORD_W 16
`define PSM_OVER_LIMIT_BIT 9
`define PSM_MASK_PRESET 16'h7fff
// Power figures are carried in tenths of a watt.
`define PSM_LIMIT_MIN 16'h0000
`define PSM_LIMIT_MAX_LOW 16'h2422
`define PSM_LIMIT_MAX_HIGH 16'h2710
// Error code for a value out of range, carried as a positive magnitude.
`define PSM_ERR_OUT_OF_RANGE 16'h00de
`define PSM_ERR_NONE 16'h0000

`endif

// ===== core/psm_pkg.sv
`default_nettype none

package psm_pkg;
  // Requests that the host command interpreter can issue to the block.
  typedef enum logic [3:0] {
    psm_cmd_none,
    psm_cmd_read_power_condition,
    psm_cmd_read_power_event,
    psm_cmd_write_power_enable_mask,
    psm_cmd_read_power_enable_mask,
    psm_cmd_set_power_limit,
    psm_cmd_set_power_limit_min,
    psm_cmd_set_power_limit_max,
    psm_cmd_read_power_limit,
    psm_cmd_read_present_power,
    psm_cmd_read_peak_power_since_service,
    psm_cmd_status_preset,
    psm_cmd_clear_status
  } psm_cmd_t;
endpackage

`default_nettype wire

// ===== core/psm_peak_track.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_defs.svh"

// Running maximum of the measured power, seeded from storage at power on.
module psm_peak_track #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Seed value and load strobe.
  input wire logic seed_load,
  input wire logic [WIDTH-1:0] seed_value,
  // Sample stream.
  input wire logic sample_valid,
  input wire logic [WIDTH-1:0] sample_value,
  // Tracked maximum.
  output logic [WIDTH-1:0] peak_value
);

  // -----------------------------------------------------------------------------
  // Peak register
  // -----------------------------------------------------------------------------

  // The seed wins over a sample so that a service reset is never overwritten.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      peak_value <= '0;
    end else if (seed_load) begin
      peak_value <= seed_value;
    end else if (sample_valid && (sample_value > peak_value)) begin
      peak_value <= sample_value;
    end
  end

endmodule
`default_nettype wire

// ===== core/psm_power_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_defs.svh"

module psm_power_status_monitor
  import psm_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter bit HIGH_POWER_MODEL = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Command request from the host interpreter, one cycle per command.
  input wire logic cmd_valid,
  input wire psm_cmd_t cmd_code,
  input wire logic [31:0] cmd_data,
  // Power-on restore from nonvolatile storage.
  input wire logic power_on_status_clear_flag,
  input wire logic [WIDTH-1:0] stored_enable_mask,
  input wire logic [WIDTH-1:0] stored_peak_power,
  // Measurement from the supply monitor, tenths of a watt.
  input wire logic power_sample_valid,
  input wire logic [WIDTH-1:0] power_sample,
  // Answer to the host.
  output logic resp_valid,
  output logic [WIDTH-1:0] resp_data,
  output logic resp_error,
  output logic [WIDTH-1:0] resp_error_code,
  // Status summary.
  output logic power_summary
);

  // -----------------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------------

  localparam logic [WIDTH-1:0] LIMIT_MAX =
    HIGH_POWER_MODEL ? `PSM_LIMIT_MAX_HIGH : `PSM_LIMIT_MAX_LOW;

  logic [WIDTH-1:0] enable_mask_reg;
  logic [WIDTH-1:0] limit_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] event_reg;
  logic [WIDTH-1:0] condition_reg;
  logic [WIDTH-1:0] peak_power;
  logic over_prev_reg;
  logic init_pending_reg;
  logic init_pulse;
  logic over_limit;
  logic event_clear;
  logic cmd_read_event;

  // -----------------------------------------------------------------------------
  // Power-on initialisation
  // -----------------------------------------------------------------------------

  // Straps are sampled one edge after reset release, never inside the reset.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      init_pending_reg <= 1'b1;
    end else begin
      init_pending_reg <= 1'b0;
    end
  end
  assign init_pulse = init_pending_reg;

  // -----------------------------------------------------------------------------
  // Measurement, limit compare and condition
  // -----------------------------------------------------------------------------

  // Latest measured level.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      level_reg <= '0;
    end else if (power_sample_valid) begin
      level_reg <= power_sample;
    end
  end

  assign over_limit = (level_reg > limit_reg);

  // Condition holds only bit 9; reads never touch it.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      condition_reg <= '0;
    end else begin
      condition_reg <= '0;
      condition_reg[`PSM_OVER_LIMIT_BIT] <= over_limit;
    end
  end

  // -----------------------------------------------------------------------------
  // Event register
  // -----------------------------------------------------------------------------

  assign cmd_read_event = cmd_valid && (cmd_code == psm_cmd_read_power_event);
  assign event_clear = cmd_read_event ||
                       (cmd_valid && (cmd_code == psm_cmd_clear_status));

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      over_prev_reg <= 1'b0;
    end else begin
      over_prev_reg <= condition_reg[`PSM_OVER_LIMIT_BIT];
    end
  end

  // A rising condition sets the event; a set in the clear cycle is kept.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      event_reg <= '0;
    end else if (condition_reg[`PSM_OVER_LIMIT_BIT] && !over_prev_reg) begin
      event_reg[`PSM_OVER_LIMIT_BIT] <= 1'b1;
    end else if (event_clear) begin
      event_reg <= '0;
    end
  end

  // -----------------------------------------------------------------------------
  // Enable mask and limit
  // -----------------------------------------------------------------------------

  // Any 16-bit pattern is legal; unused bits are stored but only bit 9 is used.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enable_mask_reg <= `PSM_MASK_PRESET;
    end else if (init_pulse) begin
      enable_mask_reg <= power_on_status_clear_flag ?
                         `PSM_MASK_PRESET : stored_enable_mask;
    end else if (cmd_valid && (cmd_code == psm_cmd_status_preset)) begin
      enable_mask_reg <= `PSM_MASK_PRESET;
    end else if (cmd_valid && (cmd_code == psm_cmd_write_power_enable_mask) &&
                 (cmd_data[31:WIDTH] == '0)) begin
      enable_mask_reg <= cmd_data[WIDTH-1:0];
    end
  end

  // Limit powers up at the model maximum so only a level above that maximum trips before it is set.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      limit_reg <= LIMIT_MAX;
    end else if (cmd_valid) begin
      if (cmd_code == psm_cmd_set_power_limit_min) begin
        limit_reg <= `PSM_LIMIT_MIN;
      end else if (cmd_code == psm_cmd_set_power_limit_max) begin
        limit_reg <= LIMIT_MAX;
      end else if ((cmd_code == psm_cmd_set_power_limit) &&
                   (cmd_data <= {{(32-WIDTH){1'b0}}, LIMIT_MAX})) begin
        limit_reg <= cmd_data[WIDTH-1:0];
      end
    end
  end

  // -----------------------------------------------------------------------------
  // Peak tracking
  // -----------------------------------------------------------------------------

  psm_peak_track #(
    .WIDTH(WIDTH)
  ) u_peak (
    .sys_clk(sys_clk),
    .reset(reset),
    .seed_load(init_pulse),
    .seed_value(stored_peak_power),
    .sample_valid(power_sample_valid),
    .sample_value(power_sample),
    .peak_value(peak_power)
  );

  // -----------------------------------------------------------------------------
  // Answers
  // -----------------------------------------------------------------------------

  // Every command gets one answer one cycle later; errors come with data zero.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp_data <= '0;
      resp_error <= 1'b0;
      resp_error_code <= `PSM_ERR_NONE;
    end else begin
      resp_valid <= cmd_valid;
      resp_data <= '0;
      resp_error <= 1'b0;
      resp_error_code <= `PSM_ERR_NONE;
      if (cmd_valid) begin
        case (cmd_code)
          psm_cmd_read_power_condition: begin
            resp_data <= condition_reg;
          end
          psm_cmd_read_power_event: begin
            resp_data <= event_reg;
          end
          psm_cmd_read_power_enable_mask: begin
            resp_data <= enable_mask_reg;
          end
          psm_cmd_read_power_limit: begin
            resp_data <= limit_reg;
          end
          psm_cmd_read_present_power: begin
            resp_data <= level_reg;
          end
          psm_cmd_read_peak_power_since_service: begin
            resp_data <= peak_power;
          end
          psm_cmd_write_power_enable_mask: begin
            if (cmd_data[31:WIDTH] != '0) begin
              resp_error <= 1'b1;
              resp_error_code <= `PSM_ERR_OUT_OF_RANGE;
            end
          end
          psm_cmd_set_power_limit: begin
            if (cmd_data > {{(32-WIDTH){1'b0}}, LIMIT_MAX}) begin
              resp_error <= 1'b1;
              resp_error_code <= `PSM_ERR_OUT_OF_RANGE;
            end
          end
          default: begin
            resp_data <= '0;
          end
        endcase
      end
    end
  end

  // Summary: only the defined bit passes the mask, so undefined bits do nothing.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_summary <= 1'b0;
    end else begin
      power_summary <= event_reg[`PSM_OVER_LIMIT_BIT] &&
                       enable_mask_reg[`PSM_OVER_LIMIT_BIT];
    end
  end

endmodule
`default_nettype wire

// ===== tb/psm_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_defs.svh"

// ------------------------------------------
// Port checker for the power status monitor.
// ------------------------------------------
module psm_checker
  import psm_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter bit HIGH_POWER_MODEL = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Command and measurement inputs.
  input wire logic cmd_valid,
  input wire psm_cmd_t cmd_code,
  input wire logic [31:0] cmd_data,
  input wire logic power_sample_valid,
  input wire logic [WIDTH-1:0] power_sample,
  // Answer to the host.
  input wire logic resp_valid,
  input wire logic [WIDTH-1:0] resp_data,
  input wire logic resp_error,
  input wire logic [WIDTH-1:0] resp_error_code
);
  // The model maximum decides where a limit write turns into a refusal.
  localparam logic [31:0] LMAX =
    {16'h0000, HIGH_POWER_MODEL ? `PSM_LIMIT_MAX_HIGH : `PSM_LIMIT_MAX_LOW};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // A command of one kind taken at this edge.
  sequence s_cmd(c);
    cmd_valid && cmd_code == c;
  endsequence

  // A sample, a quiet cycle, then a read of the present level.
  sequence s_fresh_read;
    power_sample_valid ##1 !power_sample_valid ##1 s_cmd(psm_cmd_read_present_power);
  endsequence

  chk_answer_once: assert property (cmd_valid |=> resp_valid)
    else $error("command not answered one cycle later");
  chk_no_stray: assert property (!cmd_valid |=> !resp_valid && !resp_error)
    else $error("answer without a command");
  // Error flag and code always travel together.
  property p_error_code;
    resp_valid |-> resp_error_code == (resp_error ? `PSM_ERR_OUT_OF_RANGE : `PSM_ERR_NONE);
  endproperty

  // Mask writes: anything above bit 15 is refused, the rest is taken.
  property p_mask_reject;
    s_cmd(psm_cmd_write_power_enable_mask) ##0 cmd_data[31:16] != 16'h0000 |=> resp_error;
  endproperty
  property p_mask_accept;
    s_cmd(psm_cmd_write_power_enable_mask) ##0 cmd_data[31:16] == 16'h0000 |=> !resp_error;
  endproperty

  // Limit writes: the model maximum is the last legal value.
  property p_limit_reject;
    s_cmd(psm_cmd_set_power_limit) ##0 cmd_data > LMAX |=> resp_error;
  endproperty
  property p_limit_accept;
    s_cmd(psm_cmd_set_power_limit) ##0 cmd_data <= LMAX |=> !resp_error;
  endproperty

  // Only the over-limit bit of the condition word may ever be set.
  property p_cond_zero;
    s_cmd(psm_cmd_read_power_condition) |=>
      resp_data[15:10] == 6'h00 && resp_data[8:0] == 9'h000;
  endproperty

  // A preset followed by a mask read returns the preset pattern.
  property p_preset_load;
    s_cmd(psm_cmd_status_preset) ##2 s_cmd(psm_cmd_read_power_enable_mask) |=>
      resp_data == `PSM_MASK_PRESET;
  endproperty

  chk_error_code: assert property (p_error_code)
    else $error("error code does not match error flag");
  chk_mask_reject: assert property (p_mask_reject)
    else $error("wide mask write not refused");
  chk_mask_accept: assert property (p_mask_accept)
    else $error("legal mask write refused");
  chk_limit_reject: assert property (p_limit_reject)
    else $error("limit above maximum not refused");
  chk_limit_accept: assert property (p_limit_accept)
    else $error("legal limit refused");
  chk_cond_zero: assert property (p_cond_zero)
    else $error("undefined condition bit set");
  chk_level_fresh: assert property (s_fresh_read |=> resp_data == $past(power_sample, 3))
    else $error("present level differs from last sample");
  chk_preset_load: assert property (p_preset_load)
    else $error("mask not preset");
endmodule
`default_nettype wire

// ===== tb/psm_power_status_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_defs.svh"

module psm_power_status_monitor_bench
  import psm_pkg::*;
  ;
  localparam logic [15:0] LMAX = `PSM_LIMIT_MAX_LOW;
  logic sys_clk, reset, cmd_valid, flag, ps_valid, resp_valid, resp_error, power_summary;
  psm_cmd_t cmd_code;
  logic [31:0] cmd_data;
  logic [15:0] st_mask, st_peak, ps, resp_data, resp_error_code;
  int num_errors = 0;
  int check_count = 0;

  psm_power_status_monitor #(.WIDTH(16), .HIGH_POWER_MODEL(1'b0)) DUT (
    .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .power_on_status_clear_flag(flag), .stored_enable_mask(st_mask),
    .stored_peak_power(st_peak), .power_sample_valid(ps_valid), .power_sample(ps),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_error(resp_error),
    .resp_error_code(resp_error_code), .power_summary(power_summary));

  // A 40 ns clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ------------------------------------
  // Shared tasks.
  // ------------------------------------
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command; the answer stands for one cycle only, so it is checked at once.
  task automatic cmd(input psm_cmd_t c, input logic [31:0] d, input logic [15:0] exp,
                     input logic err);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    check_val("resp_valid", 16'h0001, {15'h0000, resp_valid});
    check_val("resp_data", exp, resp_data);
    check_val("resp_error", {15'h0000, err}, {15'h0000, resp_error});
    check_val("resp_error_code", err ? `PSM_ERR_OUT_OF_RANGE : `PSM_ERR_NONE, resp_error_code);
  endtask

  // One measurement, then a number of idle cycles for the status chain.
  task automatic sample(input logic [15:0] v, input int settle);
    @(negedge sys_clk);
    ps_valid = 1'b1;
    ps = v;
    @(negedge sys_clk);
    ps_valid = 1'b0;
    repeat (settle) @(negedge sys_clk);
  endtask

  // Power-on with a chosen clear flag; commands wait two edges for the restore.
  task automatic do_reset(input logic f, input int cycles);
    reset = 1'b1;
    flag = f;
    repeat (cycles) @(negedge sys_clk);
    reset = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The whole run needs about 120 cycles, so this limit is generous.
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    $display("mismatch watchdog expected done seen timeout");
    final_report();
  end

  // ------------------------------------
  // Test sequence.
  // ------------------------------------
  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = psm_cmd_none;
    cmd_data = 32'h0000_0000;
    ps_valid = 1'b0;
    ps = 16'h0000;
    st_mask = 16'h1234;
    st_peak = 16'h0100;
    do_reset(1'b0, 12);
    cmd(psm_cmd_read_power_enable_mask, 0, 16'h1234, 0);
    cmd(psm_cmd_read_peak_power_since_service, 0, 16'h0100, 0);
    cmd(psm_cmd_read_power_condition, 0, 16'h0000, 0);
    $display("test restore done");
    cmd(psm_cmd_write_power_enable_mask, 32'h0000_3fff, 16'h0000, 0);
    cmd(psm_cmd_read_power_enable_mask, 0, 16'h3fff, 0);
    cmd(psm_cmd_write_power_enable_mask, 32'h0001_0000, 16'h0000, 1);
    cmd(psm_cmd_read_power_enable_mask, 0, 16'h3fff, 0);
    cmd(psm_cmd_write_power_enable_mask, 32'h0000_ffff, 16'h0000, 0);
    cmd(psm_cmd_status_preset, 0, 16'h0000, 0);
    cmd(psm_cmd_read_power_enable_mask, 0, `PSM_MASK_PRESET, 0);
    $display("test mask done");
    cmd(psm_cmd_set_power_limit, {16'h0000, LMAX + 16'h0001}, 16'h0000, 1);
    cmd(psm_cmd_read_power_limit, 0, LMAX, 0);
    cmd(psm_cmd_set_power_limit_min, 0, 16'h0000, 0);
    cmd(psm_cmd_read_power_limit, 0, `PSM_LIMIT_MIN, 0);
    cmd(psm_cmd_set_power_limit, {16'h0000, LMAX}, 16'h0000, 0);
    cmd(psm_cmd_set_power_limit_min, 0, 16'h0000, 0);
    cmd(psm_cmd_set_power_limit_max, 0, 16'h0000, 0);
    cmd(psm_cmd_read_power_limit, 0, LMAX, 0);
    cmd(psm_cmd_set_power_limit, 32'h0001_0000, 16'h0000, 1);
    cmd(psm_cmd_set_power_limit, 32'h0000_1a5e, 16'h0000, 0);
    cmd(psm_cmd_read_power_limit, 0, 16'h1a5e, 0);
    $display("test limit done");
    sample(16'h1a5e, 5);
    cmd(psm_cmd_read_power_condition, 0, 16'h0000, 0);
    sample(16'h1a5f, 0);
    cmd(psm_cmd_read_present_power, 0, 16'h1a5f, 0);
    repeat (5) @(negedge sys_clk);
    cmd(psm_cmd_read_power_condition, 0, 16'h0200, 0);
    cmd(psm_cmd_read_power_condition, 0, 16'h0200, 0);
    check_val("power_summary", 16'h0001, {15'h0000, power_summary});
    cmd(psm_cmd_read_power_event, 0, 16'h0200, 0);
    cmd(psm_cmd_read_power_event, 0, 16'h0000, 0);
    check_val("power_summary", 16'h0000, {15'h0000, power_summary});
    cmd(psm_cmd_read_peak_power_since_service, 0, 16'h1a5f, 0);
    $display("test over limit done");
    sample(16'h0000, 5);
    cmd(psm_cmd_read_power_condition, 0, 16'h0000, 0);
    cmd(psm_cmd_read_peak_power_since_service, 0, 16'h1a5f, 0);
    sample(16'h2000, 5);
    check_val("power_summary", 16'h0001, {15'h0000, power_summary});
    cmd(psm_cmd_clear_status, 0, 16'h0000, 0);
    cmd(psm_cmd_read_power_event, 0, 16'h0000, 0);
    $display("test clear done");
    do_reset(1'b1, 3);
    cmd(psm_cmd_read_power_enable_mask, 0, `PSM_MASK_PRESET, 0);
    cmd(psm_cmd_read_peak_power_since_service, 0, 16'h0100, 0);
    cmd(psm_cmd_read_power_condition, 0, 16'h0000, 0);
    $display("test second reset done");
    final_report();
  end
endmodule

bind psm_power_status_monitor psm_checker #(.WIDTH(WIDTH),
  .HIGH_POWER_MODEL(HIGH_POWER_MODEL)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_data(cmd_data), .power_sample_valid(power_sample_valid), .power_sample(power_sample),
  .resp_valid(resp_valid), .resp_data(resp_data), .resp_error(resp_error),
  .resp_error_code(resp_error_code));
`default_nettype wire
